// >>> hdl/timer16_defines.svh
`ifndef TIMER16_DEFINES_SVH
`define TIMER16_DEFINES_SVH

// register map on the 8-bit i/o port
`define ADDR_W 4
`define OFF_CTRL_A 4'h0
`define OFF_CTRL_B 4'h1
`define OFF_CNT_L 4'h2
`define OFF_CNT_H 4'h3
`define OFF_CAPT_L 4'h4
`define OFF_CAPT_H 4'h5
`define OFF_CMPA_L 4'h6
`define OFF_CMPA_H 4'h7
`define OFF_MASK 4'h8
`define OFF_FLAGS 4'h9

// field positions
`define BIT_WGM_LO 1
`define BIT_CS_HI 2
`define BIT_WGM_HI_H 4
`define BIT_WGM_HI_L 3
`define BIT_CAP_SRC 5
`define BIT_CAP_EDGE 6
`define BIT_OVF 0
`define BIT_CAPF 5

// count landmarks and reset values
`define CNT_BOTTOM 16'h0000
`define CNT_MAX 16'hffff
`define TOP_8BIT 16'h00ff
`define TOP_9BIT 16'h01ff
`define TOP_10BIT 16'h03ff
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`define CS_STOP 3'h0
`define CS_SYSCLK 3'h1
`define CS_EXT_FALL 3'h6
`define CS_EXT_RISE 3'h7

`endif

// >>> hdl/timer16_pkg.sv
package timer16_pkg;
    // counting direction of the dual-slope sequences
    typedef enum logic {
        DIR_UP = 1'b0,
        DIR_DOWN = 1'b1
    } dir_t;
    // waveform mode field
    typedef logic [3:0] wave_mode_t;
endpackage

// >>> hdl/timer16_counter_capture.sv
// How it works
// R1: 16-bit up/down counter seen as two byte locations, upper and lower.
// R2: high byte hits shared latch; low read fills latch, low write loads upper.
// R3: each tick clears, increments or decrements the counter per mode.
// R4: three-bit source field in control b picks tick; zero stops it.
// R5: counter is readable and writable whether or not the tick runs.
// R6: a processor counter write beats any clear or count that cycle.
// R7: four-bit waveform mode, split over control a and b, sets the sequence.
// R8: overflow flag sets where the mode says and can raise an interrupt.
// R9: matching edge on pin or comparator copies counter into capture register.
// R10: capture flag sets in the same cycle the capture register loads.
// R11: with capture enable set the flag interrupts; servicing clears it.
// R12: writing one to the capture flag bit clears it.
// R13: capture read low first fills latch; high read returns the latch.
// R14: capture register is writable only in modes using it as top.
// R15: software writes capture high byte before the low byte.
// R16: one latch load may serve several low-byte writes sharing a high byte.
// R17: software masks interrupts around two-byte writes to protect the latch.
// R18: one latch shared by all 16-bit registers; low write loads both bytes.
// R19: compare register reads return both bytes directly, no latch.
// R20: bottom 0x0000, max 0xffff, top fixed, compare a or capture per mode.
// R21: reset zeroes counter, capture, latch, flag, and stops the source.
`timescale 1ns/1ns
`include "timer16_defines.svh"
`default_nettype none
module timer16_counter_capture (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic [`ADDR_W-1:0] i_addr,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] i_wdata,
    input wire logic i_prescaled_tick,
    input wire logic i_ext_clock,
    input wire logic i_capture_pin,
    input wire logic i_comparator_output,
    input wire logic i_capture_ack,
    input wire logic i_overflow_ack,
    output logic [7:0] o_rdata,
    output logic o_capture_irq,
    output logic o_overflow_irq
);
    import timer16_pkg::*;

    logic [7:0] ctrl_a_ff;
    logic [7:0] ctrl_b_ff;
    logic [7:0] mask_ff;
    logic [15:0] count_ff;
    logic [15:0] capt_ff;
    logic [15:0] comp_a_ff;
    logic [7:0] temp_ff;
    dir_t dir_ff;
    logic ovf_ff;
    logic capf_ff;
    logic [7:0] rdata_ff;
    logic cap_irq_ff;
    logic ovf_irq_ff;
    logic ext_prev_ff;
    logic cap_prev_ff;
    logic [7:0] nxt_rdata;
    logic nxt_ovf;
    logic nxt_capf;

    // decoding used by several processes
    function automatic logic is_icr_top(input wave_mode_t m);
        return (m == 4'h8) || (m == 4'ha) || (m == 4'hc) || (m == 4'he);
    endfunction

    function automatic logic is_dual(input wave_mode_t m);
        return (m >= 4'h1 && m <= 4'h3) || (m >= 4'h8 && m <= 4'hb);
    endfunction

    function automatic logic is_fast(input wave_mode_t m);
        return (m >= 4'h5 && m <= 4'h7) || (m == 4'he) || (m == 4'hf);
    endfunction

    // R20: top per mode
    function automatic logic [15:0] top_of(input wave_mode_t m, input logic [15:0] cmp,
                                            input logic [15:0] cap);
        case (m)
            4'h1, 4'h5: top_of = `TOP_8BIT;
            4'h2, 4'h6: top_of = `TOP_9BIT;
            4'h3, 4'h7: top_of = `TOP_10BIT;
            4'h4, 4'h9, 4'hb, 4'hf: top_of = cmp;
            4'h8, 4'ha, 4'hc, 4'he: top_of = cap;
            default: top_of = `CNT_MAX;
        endcase
    endfunction

    // R7: mode field split over both control registers
    wave_mode_t wgm;
    assign wgm = {ctrl_b_ff[`BIT_WGM_HI_H:`BIT_WGM_HI_L], ctrl_a_ff[`BIT_WGM_LO:0]};

    logic [2:0] cs;
    assign cs = ctrl_b_ff[`BIT_CS_HI:0];

    logic [15:0] top;
    assign top = top_of(wgm, comp_a_ff, capt_ff);

    logic cnt_lo_wr;
    logic capt_lo_wr;
    assign cnt_lo_wr = i_wr && (i_addr == `OFF_CNT_L);
    assign capt_lo_wr = i_wr && (i_addr == `OFF_CAPT_L);

    // R4: tick source select, zero stops the timer
    logic tick;
    always_comb begin
        case (cs)
            `CS_STOP: tick = 1'b0;
            `CS_SYSCLK: tick = 1'b1;
            `CS_EXT_FALL: tick = ext_prev_ff && !i_ext_clock;
            `CS_EXT_RISE: tick = !ext_prev_ff && i_ext_clock;
            default: tick = i_prescaled_tick;
        endcase
    end

    // previous samples for edge detection
    logic cap_src;
    assign cap_src = ctrl_b_ff[`BIT_CAP_SRC] ? i_comparator_output : i_capture_pin;
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            ext_prev_ff <= 1'b0;
            cap_prev_ff <= 1'b0;
        end else begin
            ext_prev_ff <= i_ext_clock;
            cap_prev_ff <= cap_src;
        end
    end

    // R9: capture event, off while capture defines top
    logic cap_evt;
    assign cap_evt = (cap_src != cap_prev_ff) && (cap_src == ctrl_b_ff[`BIT_CAP_EDGE])
                     && !is_icr_top(wgm);

    // control, mask and compare registers
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            ctrl_a_ff <= `RST_BYTE;
            ctrl_b_ff <= `RST_BYTE;
            mask_ff <= `RST_BYTE;
            comp_a_ff <= `RST_WORD;
        end else if (i_wr) begin
            case (i_addr)
                `OFF_CTRL_A: ctrl_a_ff <= i_wdata;
                `OFF_CTRL_B: ctrl_b_ff <= i_wdata;
                `OFF_MASK: mask_ff <= i_wdata;
                // R18: compare low write joins latch byte
                `OFF_CMPA_L: comp_a_ff <= {temp_ff, i_wdata};
                default: ;
            endcase
        end
    end

    // R2: shared high-byte latch
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            temp_ff <= `RST_BYTE;
        end else if (i_wr && (i_addr == `OFF_CNT_H || i_addr == `OFF_CAPT_H
                              || i_addr == `OFF_CMPA_H)) begin
            temp_ff <= i_wdata;
        end else if (i_rd && i_addr == `OFF_CNT_L) begin
            temp_ff <= count_ff[15:8];
        end else if (i_rd && i_addr == `OFF_CAPT_L) begin
            // R13: low capture read fills latch
            temp_ff <= capt_ff[15:8];
        end
    end

    // counter unit, tick-driven sequence
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            count_ff <= `RST_WORD;
            dir_ff <= DIR_UP;
        end else if (cnt_lo_wr) begin
            // R6: write wins over count
            count_ff <= {temp_ff, i_wdata};
        end else if (tick) begin
            // R3: clear, up or down per mode
            if (is_dual(wgm)) begin
                if (dir_ff == DIR_UP) begin
                    if (count_ff >= top) begin
                        dir_ff <= DIR_DOWN;
                        count_ff <= count_ff - 16'h0001;
                    end else begin
                        count_ff <= count_ff + 16'h0001;
                    end
                end else if (count_ff == `CNT_BOTTOM) begin
                    dir_ff <= DIR_UP;
                    count_ff <= count_ff + 16'h0001;
                end else begin
                    count_ff <= count_ff - 16'h0001;
                end
            end else if (count_ff == top) begin
                count_ff <= `CNT_BOTTOM;
                dir_ff <= DIR_UP;
            end else begin
                count_ff <= count_ff + 16'h0001;
                dir_ff <= DIR_UP;
            end
        end
    end

    // R8: overflow point per mode
    logic ovf_evt;
    always_comb begin
        if (!tick || cnt_lo_wr) begin
            ovf_evt = 1'b0;
        end else if (is_dual(wgm)) begin
            ovf_evt = (count_ff == `CNT_BOTTOM) && (dir_ff == DIR_DOWN);
        end else if (is_fast(wgm)) begin
            ovf_evt = (count_ff == top);
        end else begin
            ovf_evt = (count_ff == `CNT_MAX);
        end
    end

    // capture register
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            capt_ff <= `RST_WORD;
        end else if (cap_evt) begin
            capt_ff <= count_ff;
        end else if (capt_lo_wr && is_icr_top(wgm)) begin
            // R14: write only when capture sets top
            capt_ff <= {temp_ff, i_wdata};
        end
    end

    // flags: set beats write-one clear and acknowledge
    always_comb begin
        nxt_ovf = ovf_ff;
        nxt_capf = capf_ff;
        if (i_overflow_ack || (i_wr && i_addr == `OFF_FLAGS && i_wdata[`BIT_OVF])) begin
            nxt_ovf = 1'b0;
        end
        // R11 R12: acknowledge or write one clears
        if (i_capture_ack || (i_wr && i_addr == `OFF_FLAGS && i_wdata[`BIT_CAPF])) begin
            nxt_capf = 1'b0;
        end
        if (ovf_evt) begin
            nxt_ovf = 1'b1;
        end
        // R10: flag with capture copy
        if (cap_evt) begin
            nxt_capf = 1'b1;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            ovf_ff <= 1'b0;
            capf_ff <= 1'b0;
            cap_irq_ff <= 1'b0;
            ovf_irq_ff <= 1'b0;
        end else begin
            ovf_ff <= nxt_ovf;
            capf_ff <= nxt_capf;
            // R11: masked interrupt requests
            cap_irq_ff <= nxt_capf && mask_ff[`BIT_CAPF];
            ovf_irq_ff <= nxt_ovf && mask_ff[`BIT_OVF];
        end
    end

    // read data mux, registered
    always_comb begin
        nxt_rdata = 8'h00;
        case (i_addr)
            `OFF_CTRL_A: nxt_rdata = ctrl_a_ff;
            `OFF_CTRL_B: nxt_rdata = ctrl_b_ff;
            // R1 R5: counter bytes always readable
            `OFF_CNT_L: nxt_rdata = count_ff[7:0];
            `OFF_CNT_H: nxt_rdata = temp_ff;
            `OFF_CAPT_L: nxt_rdata = capt_ff[7:0];
            `OFF_CAPT_H: nxt_rdata = temp_ff;
            // R19: compare read direct
            `OFF_CMPA_L: nxt_rdata = comp_a_ff[7:0];
            `OFF_CMPA_H: nxt_rdata = comp_a_ff[15:8];
            `OFF_MASK: nxt_rdata = mask_ff;
            `OFF_FLAGS: nxt_rdata = {2'b00, capf_ff, 4'b0000, ovf_ff};
            default: nxt_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            rdata_ff <= 8'h00;
        end else if (i_rd) begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign o_rdata = rdata_ff;
    assign o_capture_irq = cap_irq_ff;
    assign o_overflow_irq = ovf_irq_ff;

    // checks
    sequence s_hi_wr;
        i_wr && i_addr == `OFF_CNT_H;
    endsequence

    sequence s_lo_wr;
        i_wr && i_addr == `OFF_CNT_L;
    endsequence

    sequence s_capt_read;
        (i_rd && i_addr == `OFF_CAPT_L) ##1 (!i_rd && !i_wr) [*2] ##1 (i_rd && i_addr == `OFF_CAPT_H);
    endsequence

    write_priority_a: assert property ( // R6
        @(posedge i_mclk) disable iff (i_reset)
        s_lo_wr |=> count_ff == {$past(temp_ff), $past(i_wdata)})
        else $error("counter write lost to count");

    two_byte_write_a: assert property ( // R18
        @(posedge i_mclk) disable iff (i_reset)
        s_hi_wr ##1 (!i_wr && !i_rd) ##1 s_lo_wr |=> count_ff[15:8] == $past(i_wdata, 3))
        else $error("latched high byte not loaded");

    stopped_hold_a: assert property ( // R4
        @(posedge i_mclk) disable iff (i_reset)
        (cs == `CS_STOP && !cnt_lo_wr) |=> $stable(count_ff))
        else $error("stopped counter moved");

    capture_copy_a: assert property ( // R9
        @(posedge i_mclk) disable iff (i_reset)
        cap_evt |=> capt_ff == $past(count_ff) && capf_ff)
        else $error("capture copy or flag missing");

    capture_read_a: assert property ( // R13
        @(posedge i_mclk) disable iff (i_reset)
        s_capt_read |=> o_rdata == $past(capt_ff[15:8], 4))
        else $error("capture high read not from latch");

    flag_clear_a: assert property ( // R12
        @(posedge i_mclk) disable iff (i_reset)
        (i_wr && i_addr == `OFF_FLAGS && i_wdata[`BIT_CAPF] && !cap_evt) |=> !capf_ff)
        else $error("capture flag not cleared");

    ack_clear_a: assert property ( // R11
        @(posedge i_mclk) disable iff (i_reset)
        (i_capture_ack && !cap_evt) |=> !capf_ff && !o_capture_irq)
        else $error("serviced capture flag remains");

    capture_guard_a: assert property ( // R14
        @(posedge i_mclk) disable iff (i_reset)
        (capt_lo_wr && !is_icr_top(wgm) && !cap_evt) |=> $stable(capt_ff))
        else $error("capture written outside top mode");

    overflow_max_a: assert property ( // R8
        @(posedge i_mclk) disable iff (i_reset)
        (wgm == 4'h0 && tick && !cnt_lo_wr && count_ff == `CNT_MAX)
        |=> ovf_ff && count_ff == `CNT_BOTTOM)
        else $error("overflow at max missed");

    compare_read_a: assert property ( // R19
        @(posedge i_mclk) disable iff (i_reset)
        (i_rd && i_addr == `OFF_CMPA_H) |=> o_rdata == $past(comp_a_ff[15:8]))
        else $error("compare high read not direct");

    reset_state_a: assert property ( // R21
        @(posedge i_mclk)
        i_reset |=> count_ff == `RST_WORD && capt_ff == `RST_WORD
        && temp_ff == `RST_BYTE && !capf_ff && cs == `CS_STOP)
        else $error("reset state not zero");
endmodule
`default_nettype wire

// >>> sim/timer16_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
module timer16_cpu_model (
    input wire logic i_mclk,
    input wire logic [7:0] i_rdata,
    output logic [3:0] o_addr,
    output logic o_wr,
    output logic o_rd,
    output logic [7:0] o_wdata
);
    // bus starts idle, strobes low
    initial begin
        o_addr = 4'h0;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_wdata = 8'h5a;
    end

    // one write strobe, then data goes stale-inverted so it never looks valid
    task automatic wr8(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_mclk);
        o_wr <= 1'b0;
        o_wdata <= ~d;
    endtask

    // one read strobe, data taken once registered
    task automatic rd8(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_mclk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_mclk);
        o_rd <= 1'b0;
        @(posedge i_mclk);
        #1;
        d = i_rdata;
    endtask

    task automatic wr16(input logic [3:0] a, input logic [15:0] d);
        wr8(4'(a + 4'h1), d[15:8]);
        wr8(a, d[7:0]);
    endtask

    task automatic rd16(input logic [3:0] a, output logic [15:0] d);
        rd8(a, d[7:0]);
        rd8(4'(a + 4'h1), d[15:8]);
    endtask
endmodule
`default_nettype wire

// >>> sim/timer16_counter_capture_tb.sv
`timescale 1ns/1ns
`include "timer16_defines.svh"
`default_nettype none
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin n_mismatch++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, ex, gt); end end
module timer16_counter_capture_tb;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic tick = 1'b0;
    logic ext_clock = 1'b0;
    logic pin = 1'b0;
    logic comp = 1'b0;
    logic cap_ack = 1'b0;
    logic ovf_ack = 1'b0;
    logic [3:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic cap_irq;
    logic ovf_irq;
    logic [15:0] v;
    logic [15:0] w;
    logic [15:0] got;
    logic [7:0] b;
    int n_mismatch = 0;
    int tests_run = 0;

    always #5 mclk = ~mclk;

    timer16_counter_capture i_timer16_counter_capture (.i_mclk(mclk), .i_reset(reset), .i_addr(addr),
        .i_wr(wr), .i_rd(rd), .i_wdata(wdata), .i_prescaled_tick(tick), .i_ext_clock(ext_clock),
        .i_capture_pin(pin), .i_comparator_output(comp), .i_capture_ack(cap_ack),
        .i_overflow_ack(ovf_ack), .o_rdata(rdata), .o_capture_irq(cap_irq), .o_overflow_irq(ovf_irq));

    timer16_cpu_model i_timer16_cpu_model (.i_mclk(mclk), .i_rdata(rdata), .o_addr(addr), .o_wr(wr),
        .o_rd(rd), .o_wdata(wdata));

    // mode, tick source and capture edge/source bits
    task automatic cfg(input logic [3:0] m, input logic [2:0] s, input logic [1:0] x);
        i_timer16_cpu_model.wr8(`OFF_CTRL_A, {6'h00, m[1:0]});
        i_timer16_cpu_model.wr8(`OFF_CTRL_B, {1'b0, x, m[3:2], s});
    endtask

    // n one-cycle prescaled ticks
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge mclk);
            tick <= 1'b1;
            @(posedge mclk);
            tick <= 1'b0;
        end
    endtask

    // n one-cycle pulses on the external tick pin
    task automatic edges(input int n);
        repeat (n) begin
            @(posedge mclk);
            ext_clock <= 1'b1;
            @(posedge mclk);
            ext_clock <= 1'b0;
        end
    endtask

    // fixed top of the fixed-resolution modes
    function automatic logic [15:0] fixed_top(input logic [3:0] m);
        case (m[1:0])
            2'h1: return `TOP_8BIT;
            2'h2: return `TOP_9BIT;
            default: return `TOP_10BIT;
        endcase
    endfunction

    // one-cycle serviced pulse
    task automatic ack(input logic cap);
        @(posedge mclk);
        cap_ack <= cap;
        ovf_ack <= ~cap;
        @(posedge mclk);
        cap_ack <= 1'b0;
        ovf_ack <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // cut a hang short
    initial begin
        #200000;
        n_mismatch++;
        summarize();
    end

    initial begin
        void'($urandom(87));
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        i_timer16_cpu_model.rd16(`OFF_CNT_L, got);
        `CHK("count reset", 16'h0000, got)
        i_timer16_cpu_model.rd16(`OFF_CAPT_L, got);
        `CHK("capture reset", 16'h0000, got)
        i_timer16_cpu_model.rd8(`OFF_FLAGS, b);
        `CHK("flags reset", 8'h00, b)
        repeat (4) begin
            v = 16'($urandom());
            i_timer16_cpu_model.wr16(`OFF_CNT_L, v);
            i_timer16_cpu_model.rd16(`OFF_CNT_L, got);
            `CHK("count word", v, got)
        end
        // one latch load, compare read direct
        v = 16'($urandom());
        i_timer16_cpu_model.wr8(`OFF_CNT_H, v[15:8]);
        i_timer16_cpu_model.wr8(`OFF_CMPA_L, v[7:0]);
        i_timer16_cpu_model.wr8(`OFF_CNT_L, ~v[7:0]);
        i_timer16_cpu_model.rd16(`OFF_CNT_L, got);
        `CHK("latch reuse", {v[15:8], ~v[7:0]}, got)
        i_timer16_cpu_model.wr16(`OFF_CNT_L, ~v);
        i_timer16_cpu_model.rd16(`OFF_CMPA_L, got);
        `CHK("compare direct", v, got)
        // count up past max, overflow flag and irq
        cfg(4'h0, 3'h2, 2'b00);
        i_timer16_cpu_model.wr16(`OFF_CNT_L, 16'hfffd);
        pulse(2);
        i_timer16_cpu_model.rd16(`OFF_CNT_L, got);
        `CHK("count max", 16'hffff, got)
        pulse(1);
        i_timer16_cpu_model.wr8(`OFF_MASK, 8'h01);
        i_timer16_cpu_model.rd16(`OFF_CNT_L, got);
        `CHK("count wrap", 16'h0000, got)
        i_timer16_cpu_model.rd8(`OFF_FLAGS, b);
        `CHK("overflow flag", 1'b1, b[`BIT_OVF])
        `CHK("overflow irq", 1'b1, ovf_irq)
        ack(1'b0);
        `CHK("overflow irq off", 1'b0, ovf_irq)
        cfg(4'h0, 3'h0, 2'b00);
        pulse(3);
        i_timer16_cpu_model.rd16(`OFF_CNT_L, got);
        `CHK("stopped", 16'h0000, got)
        cfg(4'h0, 3'h2, 2'b00);
        v = 16'($urandom());
        tick <= 1'b1;
        i_timer16_cpu_model.wr16(`OFF_CNT_L, v);
        tick <= 1'b0;
        i_timer16_cpu_model.rd16(`OFF_CNT_L, got);
        `CHK("write priority", v, got)
        // dual slope turns at fixed top
        cfg(4'h1, 3'h2, 2'b00);
        i_timer16_cpu_model.wr16(`OFF_CNT_L, 16'h00fe);
        pulse(3);
        i_timer16_cpu_model.rd16(`OFF_CNT_L, got);
        `CHK("dual turn", 16'h00fd, got)
        // dual slope overflows at bottom while counting down
        i_timer16_cpu_model.wr16(`OFF_CNT_L, 16'h0001);
        pulse(2);
        i_timer16_cpu_model.rd8(`OFF_FLAGS, b);
        `CHK("dual overflow", 1'b1, b[`BIT_OVF])
        cfg(4'h0, 3'h0, 2'b10);
        v = 16'($urandom());
        i_timer16_cpu_model.wr16(`OFF_CNT_L, v);
        i_timer16_cpu_model.wr8(`OFF_FLAGS, 8'h20);
        i_timer16_cpu_model.wr8(`OFF_MASK, 8'h20);
        @(posedge mclk);
        pin <= 1'b1;
        i_timer16_cpu_model.rd16(`OFF_CAPT_L, got);
        `CHK("capture pin", v, got)
        i_timer16_cpu_model.rd8(`OFF_FLAGS, b);
        `CHK("capture flag", 1'b1, b[`BIT_CAPF])
        `CHK("capture irq", 1'b1, cap_irq)
        ack(1'b1);
        `CHK("capture irq off", 1'b0, cap_irq)
        // wrong edge ignored, comparator falling edge taken
        w = ~v;
        i_timer16_cpu_model.wr16(`OFF_CNT_L, w);
        @(posedge mclk);
        pin <= 1'b0;
        i_timer16_cpu_model.rd8(`OFF_FLAGS, b);
        `CHK("edge mismatch", 1'b0, b[`BIT_CAPF])
        comp <= 1'b1;
        cfg(4'h0, 3'h0, 2'b01);
        i_timer16_cpu_model.wr8(`OFF_FLAGS, 8'h20);
        @(posedge mclk);
        comp <= 1'b0;
        i_timer16_cpu_model.rd16(`OFF_CAPT_L, got);
        `CHK("capture comparator", w, got)
        i_timer16_cpu_model.wr8(`OFF_FLAGS, 8'h20);
        i_timer16_cpu_model.rd8(`OFF_FLAGS, b);
        `CHK("flag w1c", 1'b0, b[`BIT_CAPF])
        cfg(4'h0, 3'h0, 2'b00);
        i_timer16_cpu_model.wr16(`OFF_CAPT_L, v);
        i_timer16_cpu_model.rd16(`OFF_CAPT_L, got);
        `CHK("capture refused", w, got)
        cfg(4'hc, 3'h0, 2'b00);
        i_timer16_cpu_model.wr16(`OFF_CAPT_L, v);
        i_timer16_cpu_model.rd16(`OFF_CAPT_L, got);
        `CHK("capture as top", v, got)
        // every clock, then external rising and falling edges
        cfg(4'h0, 3'h1, 2'b00);
        i_timer16_cpu_model.rd8(`OFF_CNT_L, b);
        i_timer16_cpu_model.rd8(`OFF_CNT_L, got[7:0]);
        `CHK("clock source", 8'(b + 8'h03), got[7:0])
        cfg(4'h0, 3'h7, 2'b00);
        i_timer16_cpu_model.wr16(`OFF_CNT_L, 16'h0000);
        edges(3);
        i_timer16_cpu_model.rd16(`OFF_CNT_L, got);
        `CHK("external rise", 16'h0003, got)
        cfg(4'h0, 3'h6, 2'b00);
        edges(2);
        i_timer16_cpu_model.rd16(`OFF_CNT_L, got);
        `CHK("external fall", 16'h0005, got)
        // single slope wraps at fixed top, compare a as top
        cfg(4'h6, 3'h2, 2'b00);
        i_timer16_cpu_model.wr8(`OFF_FLAGS, 8'h01);
        i_timer16_cpu_model.wr16(`OFF_CNT_L, fixed_top(4'h6) - 16'h0001);
        pulse(2);
        i_timer16_cpu_model.rd8(`OFF_FLAGS, b);
        `CHK("fast overflow", 1'b1, b[`BIT_OVF])
        i_timer16_cpu_model.rd16(`OFF_CNT_L, got);
        `CHK("fast wrap", 16'h0000, got)
        cfg(4'h4, 3'h2, 2'b00);
        i_timer16_cpu_model.wr16(`OFF_CMPA_L, 16'h0010);
        i_timer16_cpu_model.wr16(`OFF_CNT_L, 16'h000f);
        pulse(2);
        i_timer16_cpu_model.rd16(`OFF_CNT_L, got);
        `CHK("compare top", 16'h0000, got)
        summarize();
    end
endmodule
`default_nettype wire
